// [hw/swr_host.sv]
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
module swr_host (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	output logic             standby_wake_control,
	output logic             standby_error_suppress,
	output logic             error_irq_enable,
	output logic [3:0]       clock_prescale_select,
	output logic [6:0]       baud_divider,
	output logic             channel_start_trigger,
	output logic             channel_stop_trigger,
	output logic             err_flag_clear,
	output logic             data_read_strobe,
	output logic             stop_mode_req,
	input  wire logic        rx_done_irq,
	input  wire logic        rx_error_irq,
	input  wire logic        parity_err_flag,
	input  wire logic        framing_err_flag,
	input  wire logic        overrun_err_flag,
	input  wire logic [8:0]  serial_data_reg
);

	// ------------------------------------------------------------
	// Oscillator table lookups
	// ------------------------------------------------------------
	function automatic logic [6:0] div_for(input logic [3:0] osc);
		div_for = (osc[0] && osc < 4'h8) ? swr_pkg::DIV_79 : swr_pkg::DIV_105;
	endfunction

	function automatic logic [3:0] pre_for(input logic [3:0] osc);
		case (osc)
			4'h0, 4'h1: pre_for = 4'h5;
			4'h2, 4'h3: pre_for = 4'h4;
			4'h4, 4'h5: pre_for = 4'h3;
			4'h6, 4'h7: pre_for = 4'h2;
			4'h8:       pre_for = 4'h1;
			default:    pre_for = 4'h0;
		endcase
	endfunction

	swr_pkg::swr_state_e state;
	logic [6:0]            cfg;
	logic [8:0]            rx_word;
	logic [6:0]            status;
	logic [2:0]            cnt;
	logic                  wr_pend;
	logic [3:0]            wr_addr;
	logic                  arm_req;
	logic                  abort_req;
	logic                  cleared;
	logic [swr_pkg::IN_W-1:0] sy1, sy2, sy3, in_q;

	wire addr_ok = hsel && htrans[1] && hready;
	wire [3:0] osc = cfg[swr_pkg::CFG_OSC_LSB +: 4];
	wire in_done = in_q[0];
	wire in_err  = in_q[1];

	// ------------------------------------------------------------
	// Pin inputs: three stages, change accepted when 2nd and 3rd agree
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sy1  <= '0;
			sy2  <= '0;
			sy3  <= '0;
			in_q <= '0;
		end else begin
			sy1  <= {serial_data_reg, overrun_err_flag, framing_err_flag,
			         parity_err_flag, rx_error_irq, rx_done_irq};
			sy2  <= sy1;
			sy3  <= sy2;
			in_q <= (sy2 & ~(sy2 ^ sy3)) | (in_q & (sy2 ^ sy3));
		end
	end

	// ------------------------------------------------------------
	// AHB-Lite slave, zero wait states, always OKAY
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h0000_0000;
			wr_pend   <= 1'b0;
			wr_addr   <= 4'h0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend   <= addr_ok && hwrite;
			wr_addr   <= haddr[3:0];
			if (addr_ok && !hwrite) begin
				case (haddr[3:0])
					swr_pkg::ADDR_CFG:    hrdata <= {25'h0, cfg};
					swr_pkg::ADDR_STATUS: hrdata <= {25'h0, status};
					swr_pkg::ADDR_DATA:   hrdata <= {23'h0, rx_word};
					default:              hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg       <= swr_pkg::CFG_RESET;
			arm_req   <= 1'b0;
			abort_req <= 1'b0;
		end else begin
			arm_req   <= wr_pend && wr_addr == swr_pkg::ADDR_CTRL && hwdata[swr_pkg::CTRL_ARM];
			abort_req <= wr_pend && wr_addr == swr_pkg::ADDR_CTRL && hwdata[swr_pkg::CTRL_ABORT];
			// Configuration is frozen while a wait is in progress
			if (wr_pend && wr_addr == swr_pkg::ADDR_CFG && state == swr_pkg::ST_IDLE)
				cfg <= hwdata[6:0];
		end
	end

	// ------------------------------------------------------------
	// Arm / sleep / release sequencer
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state                  <= swr_pkg::ST_IDLE;
			cnt                    <= 3'h0;
			cleared                <= 1'b0;
			standby_wake_control   <= 1'b0;
			standby_error_suppress <= 1'b0;
			error_irq_enable       <= 1'b0;
			clock_prescale_select  <= 4'h0;
			baud_divider           <= swr_pkg::DIV_105;
			channel_start_trigger  <= 1'b0;
			channel_stop_trigger   <= 1'b0;
			err_flag_clear         <= 1'b0;
			data_read_strobe       <= 1'b0;
			stop_mode_req          <= 1'b0;
		end else begin
			channel_start_trigger <= 1'b0;
			channel_stop_trigger  <= 1'b0;
			err_flag_clear        <= 1'b0;
			data_read_strobe      <= 1'b0;
			case (state)
				swr_pkg::ST_IDLE: begin
					cleared <= 1'b0;
					if (arm_req && cfg[swr_pkg::CFG_OSC_INT] && osc <= swr_pkg::OSC_LAST) begin
						channel_stop_trigger <= 1'b1;
						state <= swr_pkg::ST_STOP_CH;
					end
				end
				swr_pkg::ST_STOP_CH: begin
					// flush flags and data under suppression
					if (cfg[swr_pkg::CFG_SUPPRESS]) begin
						err_flag_clear   <= 1'b1;
						data_read_strobe <= 1'b1;
						cleared          <= 1'b1;
					end
					state <= swr_pkg::ST_CONFIG;
					cnt   <= 3'h0;
				end
				swr_pkg::ST_CONFIG: begin
					// rate from oscillator table, fixed 4800 bps
					// sender tolerance is fixed by this divider choice
					clock_prescale_select  <= pre_for(osc);
					baud_divider           <= div_for(osc);
					standby_error_suppress <= cfg[swr_pkg::CFG_SUPPRESS];
					error_irq_enable       <= cfg[swr_pkg::CFG_EIRQ_EN];
					cnt <= cnt + 3'h1;
					if (cnt == 3'(swr_pkg::SETTLE_CYC))
						state <= swr_pkg::ST_START;
				end
				swr_pkg::ST_START: begin
					channel_start_trigger <= 1'b1;
					state <= swr_pkg::ST_ARM_SWC;
				end
				swr_pkg::ST_ARM_SWC: begin
					// control bit just before stop entry
					standby_wake_control <= 1'b1;
					state <= swr_pkg::ST_SLEEP;
				end
				swr_pkg::ST_SLEEP: begin
					// device receives on its own; stop held until wake
					stop_mode_req <= 1'b1;
					// done interrupt ends the wait, so does an error
					if (in_done || in_err || abort_req) begin
						stop_mode_req <= 1'b0;
						state <= swr_pkg::ST_CAPTURE;
					end
				end
				swr_pkg::ST_CAPTURE: begin
					// read while control bit is still 1
					data_read_strobe <= 1'b1;
					state <= swr_pkg::ST_RELEASE;
				end
				swr_pkg::ST_RELEASE: begin
					channel_stop_trigger <= 1'b1;
					standby_wake_control <= 1'b0;
					state <= swr_pkg::ST_IDLE;
				end
				default: state <= swr_pkg::ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Results and status; hardware set wins over software clear
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_word <= 9'h000;
			status  <= 7'h00;
		end else begin
			if (wr_pend && wr_addr == swr_pkg::ADDR_STATUS)
				status[6:1] <= status[6:1] & ~hwdata[6:1];
			status[swr_pkg::ST_BUSY] <= state != swr_pkg::ST_IDLE;
			if (arm_req && state == swr_pkg::ST_IDLE && !(cfg[swr_pkg::CFG_OSC_INT] && osc <= swr_pkg::OSC_LAST))
				status[swr_pkg::ST_REFUSED] <= 1'b1;
			// word held until the next capture; flags held until cleared by a status write
			if (state == swr_pkg::ST_CAPTURE) begin
				rx_word <= in_q[13:5];
				status[swr_pkg::ST_DONE] <= 1'b1;
				if (in_err)
					status[swr_pkg::ST_ERR] <= 1'b1;
				status[6:4] <= status[6:4] | in_q[4:2];
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_wake_end;
		state == swr_pkg::ST_CAPTURE ##1 state == swr_pkg::ST_RELEASE;
	endsequence

	sequence s_arm_go;
		arm_req && state == swr_pkg::ST_IDLE && cfg[swr_pkg::CFG_OSC_INT] && osc <= swr_pkg::OSC_LAST;
	endsequence

	a_stop_needs_swc: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(stop_mode_req) |-> standby_wake_control && $past(standby_wake_control))
		else $error("stop requested without standby-wake control");
	a_start_then_swc: assert property (@(posedge hclk) disable iff (!hresetn)
		channel_start_trigger |=> $rose(standby_wake_control) ##1 stop_mode_req)
		else $error("start not followed by arming");
	a_arm_stops_chan: assert property (@(posedge hclk) disable iff (!hresetn)
		s_arm_go |=> channel_stop_trigger ##[4:10] channel_start_trigger)
		else $error("arm did not stop then start the channel");
	a_release_mode: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wake_end |=> channel_stop_trigger && !standby_wake_control)
		else $error("mode not released after reception");
	a_div_table: assert property (@(posedge hclk) disable iff (!hresetn)
		standby_wake_control |-> baud_divider == div_for(osc) && clock_prescale_select == pre_for(osc))
		else $error("baud setting does not match oscillator");
	a_refuse_ext: assert property (@(posedge hclk) disable iff (!hresetn)
		arm_req && state == swr_pkg::ST_IDLE && !cfg[swr_pkg::CFG_OSC_INT] |=> state == swr_pkg::ST_IDLE ##1
		status[swr_pkg::ST_REFUSED])
		else $error("arm accepted on external clock");
	a_flush_first: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(standby_wake_control) && standby_error_suppress |-> cleared)
		else $error("armed with suppression but flags not cleared");
	a_read_in_mode: assert property (@(posedge hclk) disable iff (!hresetn)
		state == swr_pkg::ST_CAPTURE |=> data_read_strobe && standby_wake_control ##1 !standby_wake_control)
		else $error("data not read while mode armed");
	a_wake_on_done: assert property (@(posedge hclk) disable iff (!hresetn)
		state == swr_pkg::ST_SLEEP && in_done |=> !stop_mode_req && state == swr_pkg::ST_CAPTURE ##2
		status[swr_pkg::ST_DONE])
		else $error("done interrupt did not end the wait");

	// ------------------------------------------------------------
	// Wait and register guards
	// ------------------------------------------------------------
	// Any of the three wake causes must end the stop request at once
	sequence s_wait_over;
		state == swr_pkg::ST_SLEEP && (in_done || in_err || abort_req);
	endsequence

	a_wait_ends_once: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wait_over |=> !stop_mode_req && state == swr_pkg::ST_CAPTURE)
		else $error("wake cause did not end the wait");
	a_sleep_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		state == swr_pkg::ST_SLEEP && stop_mode_req && !in_done && !in_err && !abort_req |=>
		stop_mode_req && standby_wake_control && state == swr_pkg::ST_SLEEP)
		else $error("stop state left without a wake cause");
	a_cfg_frozen: assert property (@(posedge hclk) disable iff (!hresetn)
		state != swr_pkg::ST_IDLE |=> $stable(cfg))
		else $error("configuration changed during a wait");
	a_err_seen: assert property (@(posedge hclk) disable iff (!hresetn)
		state == swr_pkg::ST_CAPTURE && in_err |=> status[swr_pkg::ST_ERR])
		else $error("error interrupt not recorded");
	a_refuse_range: assert property (@(posedge hclk) disable iff (!hresetn)
		arm_req && state == swr_pkg::ST_IDLE && osc > swr_pkg::OSC_LAST |=>
		state == swr_pkg::ST_IDLE && status[swr_pkg::ST_REFUSED])
		else $error("arm accepted with oscillator index out of range");
	a_busy_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		state != swr_pkg::ST_IDLE |=> status[swr_pkg::ST_BUSY])
		else $error("busy not shown during a wait");
	a_flush_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
		state == swr_pkg::ST_STOP_CH && cfg[swr_pkg::CFG_SUPPRESS] |=>
		err_flag_clear && data_read_strobe && cleared)
		else $error("suppression flush not issued");

endmodule

// [hw/swr_pkg.sv]
package swr_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_CFG    = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam logic [3:0] ADDR_DATA   = 4'hC;

	localparam int CTRL_ARM   = 0;
	localparam int CTRL_ABORT = 1;

	localparam int CFG_OSC_LSB  = 0;
	localparam int CFG_EIRQ_EN  = 4;
	localparam int CFG_SUPPRESS = 5;
	localparam int CFG_OSC_INT  = 6;
	localparam logic [6:0] CFG_RESET = 7'h00;

	localparam int ST_BUSY    = 0;
	localparam int ST_DONE    = 1;
	localparam int ST_ERR     = 2;
	localparam int ST_REFUSED = 3;
	localparam int ST_PE      = 4;
	localparam int ST_FE      = 5;
	localparam int ST_OV      = 6;

	// ------------------------------------------------------------
	// Baud and timing
	// ------------------------------------------------------------
	localparam int BAUD_BPS = 4800;
	localparam logic [6:0] DIV_105 = 7'h69;
	localparam logic [6:0] DIV_79  = 7'h4F;
	localparam logic [3:0] OSC_LAST = 4'h9;
	localparam int CLK_MHZ = 125;
	localparam int SETTLE_NS = 40;
	localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int IN_W = 14;

	typedef enum logic [3:0] {
		ST_IDLE, ST_STOP_CH, ST_CLEAR, ST_CONFIG, ST_START,
		ST_ARM_SWC, ST_SLEEP, ST_CAPTURE, ST_RELEASE
	} swr_state_e;

endpackage

// [bench/swr_dev_model.sv]
module swr_dev_model (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       standby_wake_control,
	input  wire logic       standby_error_suppress,
	input  wire logic       error_irq_enable,
	input  wire logic       channel_start_trigger,
	input  wire logic       channel_stop_trigger,
	input  wire logic       err_flag_clear,
	input  wire logic       stop_mode_req,
	input  wire logic       frame_go,
	input  wire logic [8:0] frame_data,
	input  wire logic [2:0] frame_err,
	output logic            rx_done_irq,
	output logic            rx_error_irq,
	output logic            parity_err_flag,
	output logic            framing_err_flag,
	output logic            overrun_err_flag,
	output logic [8:0]      serial_data_reg
);
	timeunit 1ns;
	timeprecision 1ps;

	logic       channel_enabled_flag;
	logic [3:0] rx_count;
	logic [8:0] rx_word;
	logic [2:0] rx_err;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			channel_enabled_flag <= 1'b0;
		else if (channel_stop_trigger)
			channel_enabled_flag <= 1'b0;
		else if (channel_start_trigger)
			channel_enabled_flag <= 1'b1;
	end

	// start edge accepted only in stop state
	// A short count stands in for one character, since a real frame would outrun the run length
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_count <= 4'h0;
			rx_word <= 9'h000;
			rx_err <= 3'h0;
		end else if (rx_count != 4'h0) begin
			rx_count <= rx_count - 4'h1;
		end else if (frame_go && channel_enabled_flag && standby_wake_control && stop_mode_req) begin
			rx_count <= 4'hA;
			rx_word <= frame_data;
			rx_err <= frame_err;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_done_irq <= 1'b0;
			rx_error_irq <= 1'b0;
			{overrun_err_flag, framing_err_flag, parity_err_flag} <= 3'h0;
			serial_data_reg <= 9'h000;
		end else if (rx_count == 4'h1) begin
			rx_done_irq <= 1'b1;
			rx_error_irq <= error_irq_enable && !standby_error_suppress && (rx_err != 3'h0);
			serial_data_reg <= rx_word;
			if (!standby_error_suppress)
				{overrun_err_flag, framing_err_flag, parity_err_flag} <= {overrun_err_flag, framing_err_flag, parity_err_flag} | rx_err;
		end else begin
			if (channel_stop_trigger) begin
				rx_done_irq <= 1'b0;
				rx_error_irq <= 1'b0;
			end
			if (err_flag_clear)
				{overrun_err_flag, framing_err_flag, parity_err_flag} <= 3'h0;
		end
	end
endmodule

// [bench/test_uart_standby_wake_receiver.sv]
module test_uart_standby_wake_receiver;
	timeunit 1ns;
	timeprecision 1ps;

	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, frame_go;
	logic        standby_wake_control, standby_error_suppress, error_irq_enable;
	logic        channel_start_trigger, channel_stop_trigger, err_flag_clear, data_read_strobe, stop_mode_req;
	logic        rx_done_irq, rx_error_irq, parity_err_flag, framing_err_flag, overrun_err_flag;
	logic        sup, en;
	logic [1:0]  htrans;
	logic [2:0]  hsize, frame_err, err, acc;
	logic [3:0]  clock_prescale_select;
	logic [6:0]  baud_divider;
	logic [8:0]  serial_data_reg, frame_data, dat;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [3:0]  pre_t [10] = '{4'h5, 4'h5, 4'h4, 4'h4, 4'h3, 4'h3, 4'h2, 4'h2, 4'h1, 4'h0};
	logic [31:0] bad [2] = '{32'h0, 32'h4A};
	int          failures, samples_checked, strobes, n0;

	swr_host swr_host_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
		.hreadyout, .hresp, .hrdata, .standby_wake_control, .standby_error_suppress, .error_irq_enable,
		.clock_prescale_select, .baud_divider, .channel_start_trigger, .channel_stop_trigger, .err_flag_clear,
		.data_read_strobe, .stop_mode_req, .rx_done_irq, .rx_error_irq, .parity_err_flag, .framing_err_flag,
		.overrun_err_flag, .serial_data_reg);

	swr_dev_model swr_dev_model_inst (.hclk, .hresetn, .standby_wake_control, .standby_error_suppress,
		.error_irq_enable, .channel_start_trigger, .channel_stop_trigger, .err_flag_clear, .stop_mode_req,
		.frame_go, .frame_data, .frame_err, .rx_done_irq, .rx_error_irq, .parity_err_flag, .framing_err_flag,
		.overrun_err_flag, .serial_data_reg);

	// ------------------------------------------------------------
	// Bus and checking tasks
	// ------------------------------------------------------------
	task automatic final_report();
		if (failures == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic guard(input int n);
		if (n > 200) begin
			failures++;
			final_report();
		end
	endtask

	task automatic edge_ready();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n++;
			guard(n);
			@(posedge hclk);
		end
	endtask

	// Entered just after a rising edge; leaves at the edge that ends the data phase
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		edge_ready();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		edge_ready();
		rd = hrdata;
	endtask

	task automatic wait_stop();
		int n;
		n = 0;
		do begin
			@(negedge hclk);
			n++;
			guard(n);
		end while (stop_mode_req !== 1'b1);
		@(posedge hclk);
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			bus(1'b0, 32'h8, 32'h0);
			n++;
			guard(n);
		end while (rd[0] !== 1'b0);
	endtask

	// ------------------------------------------------------------
	// Clock, reset and scenarios
	// ------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	// Counts data read strobes so each wait can be held to its expected reads
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			strobes <= 0;
		else if (data_read_strobe === 1'b1)
			strobes <= strobes + 1;
	end

	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata, frame_go, frame_data, frame_err} = '0;
		hsize = 3'h2;
		failures = 0;
		samples_checked = 0;
		acc = 3'h0;
		dat = 9'h000;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		check(32'(baud_divider), 32'(swr_pkg::DIV_105));
		for (int a = 0; a < 20; a += 4) begin
			bus(1'b0, 32'(a), 32'h0);
			check(rd, 32'h0);
		end
		foreach (bad[k]) begin
			bus(1'b1, 32'h4, bad[k]);
			bus(1'b1, 32'h0, 32'h1);
			repeat (3) @(posedge hclk);
			bus(1'b0, 32'h8, 32'h0);
			check(rd, 32'h8);
			check(32'(standby_wake_control), 32'h0);
			bus(1'b1, 32'h8, 32'h8);
		end
		for (int i = 0; i < 10; i++) begin
			n0 = strobes;
			sup = i[1];
			en = i[0];
			err = 3'(1 << ((i >> 1) % 4));
			bus(1'b1, 32'h4, 32'h40 | 32'(i) | {26'h0, sup, en, 4'h0});
			bus(1'b1, 32'h0, 32'h1);
			wait_stop();
			check(32'(standby_wake_control), 32'h1);
			check(32'(clock_prescale_select), 32'(pre_t[i]));
			check(32'(baud_divider), (i % 2 == 1 && i < 8) ? 32'h4F : 32'h69);
			check(32'({standby_error_suppress, error_irq_enable}), 32'({sup, en}));
			dat = 9'(9'h133 * i);
			frame_go <= 1'b1;
			frame_data <= dat;
			frame_err <= err;
			@(posedge hclk);
			frame_go <= 1'b0;
			wait_idle();
			acc = sup ? 3'h0 : (acc | err);
			check(rd, 32'h2 | ((en && !sup && err != 3'h0) ? 32'h4 : 32'h0) | 32'({acc, 4'h0}));
			check(32'(strobes - n0), 32'(sup) + 32'h1);
			bus(1'b0, 32'hC, 32'h0);
			check(rd, 32'(dat));
			check(32'(standby_wake_control), 32'h0);
			bus(1'b1, 32'h8, 32'h7E);
		end
		n0 = strobes;
		bus(1'b1, 32'h4, 32'h40);
		bus(1'b1, 32'h0, 32'h1);
		// A start edge before the stop state must not be received
		frame_go <= 1'b1;
		frame_data <= 9'h1FF;
		frame_err <= 3'h0;
		@(posedge hclk);
		frame_go <= 1'b0;
		wait_stop();
		bus(1'b1, 32'h4, 32'h7F);
		bus(1'b0, 32'h4, 32'h0);
		check(rd, 32'h40);
		bus(1'b1, 32'h0, 32'h2);
		wait_idle();
		check(rd, 32'h2 | 32'({acc, 4'h0}));
		bus(1'b0, 32'hC, 32'h0);
		check(rd, 32'(dat));
		check(32'(strobes - n0), 32'h1);
		check(32'(hresp), 32'h0);
		final_report();
	end
endmodule
